// ### logic/ads_sequencer.sv
// converter control, halt handling, registers and interrupt flags
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module ads_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // core power state
  input wire logic haltEnter,
  input wire logic haltLeave,
  output logic wakeReq,
  output logic irqOut,
  // events of neighbouring peripherals
  input wire logic voltageDetectEvent,
  input wire logic cmp2Event,
  input wire logic cmp1Event,
  input wire logic timer1Event,
  // analog front end
  input wire logic cmpHigh,
  output logic [7:0] sarTrial,
  output logic sampleConnect,
  output logic converterPowered,
  output logic [3:0] channelSel,
  output logic [1:0] referenceSel,
  output logic [7:0] analogPinSel
);
  import ads_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  ads_sar_if #(.W(8)) sarBus (); // link to the approximation core
  logic [7:0] ctrlReg, ctrlNext; // converter_control_main
  logic [7:0] intctlReg, intctlNext; // interrupt_control
  logic [7:0] pirReg, pirNext; // peripheral_irq_flags
  logic [7:0] pieReg, pieNext; // peripheral_irq_enable
  logic [7:0] apselReg, apselNext; // analog_pin_select
  logic [7:0] refReg, refNext; // reference_config
  logic [7:0] resultReg, resultNext; // conversion_result, never reset
  logic [7:0] rdReg, rdNext; // read data
  logic irqReg, irqNext; // interrupt level
  ads_state_t stateReg, stateNext; // sequencer state
  logic [1:0] cntReg, cntNext; // delay and wait counter
  logic haltedReg, haltedNext; // core is halted
  logic pdReg, pdNext; // powered down by halt
  logic wakeReg, wakeNext; // wake pulse
  logic powerReg, powerNext; // analog power
  logic sampleReg, sampleNext; // hold switch
  logic [DIV_W-1:0] divReg, divNext; // bit period divider
  logic tickReg, tickNext; // bit period enable
  logic rcSel; // RC source selected
  logic goBit; // start/done flag
  logic active; // converter on and not halted off
  logic clockRuns; // bit period clock allowed
  logic haltAbort; // halt under oscillator clock
  logic wrCtrl; // control register write
  logic restartDiv; // align divider to a wait
  logic startNow; // start the core
  logic abortNow; // abort the core
  logic irqCause; // gated interrupt source

  assign rcSel = (ctrlReg[CTRL_CS_HI:CTRL_CS_LO] == CLK_RC);
  assign goBit = ctrlReg[CTRL_GO];
  assign active = ctrlReg[CTRL_ON] && !pdReg;
  assign clockRuns = active && !(haltedReg && !rcSel);
  assign haltAbort = haltEnter && !rcSel;
  assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
  assign irqCause = |(pirReg & pieReg) && intctlReg[INTCTL_PERIPH]
    && intctlReg[INTCTL_GLOBAL];

  // ****************************************
  // approximation core
  // ****************************************
  ads_sar_core #(.W(8)) u_core (
    .clk(clk),
    .srst(srst),
    .sar(sarBus.core)
  );
  assign sarBus.bitTick = tickReg;
  assign sarBus.start = startNow;
  assign sarBus.abort = abortNow;
  assign sarBus.cmpHigh = cmpHigh;

  // ****************************************
  // bit period divider
  // ****************************************
  // stops under halt unless the RC source runs it
  always_comb begin
    divNext = divReg + DIV_ONE;
    tickNext = 1'b0;
    if (!clockRuns || restartDiv) begin
      divNext = '0;
    end else if (divReg >= ads_period_cycles(ctrlReg[CTRL_CS_HI:CTRL_CS_LO]) - DIV_ONE) begin
      divNext = '0;
      tickNext = 1'b1;
    end
  end

  // divider registers
  always_ff @(posedge clk) begin
    if (srst) begin
      divReg <= '0;
      tickReg <= 1'b0;
    end else begin
      divReg <= divNext;
      tickReg <= tickNext;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_comb begin
    stateNext = stateReg;
    cntNext = cntReg;
    startNow = 1'b0;
    abortNow = 1'b0;
    restartDiv = 1'b0;
    if (!ctrlReg[CTRL_ON]) begin
      // converter off: idle, nothing running
      stateNext = ST_ACQ;
      abortNow = 1'b1;
    end else begin
      case (stateReg)
        ST_ACQ: begin
          // firmware set the start flag
          if (goBit && active) begin
            if (rcSel) begin
              stateNext = ST_DELAY; // lets the halt instruction run first
              cntNext = DELAY_LOAD;
            end else begin
              stateNext = ST_CONV;
              startNow = 1'b1;
            end
          end
        end
        ST_DELAY: begin
          if (!goBit) begin
            stateNext = ST_ABORT;
            cntNext = ABORT_LOAD;
            restartDiv = 1'b1;
          end else if (cntReg == CNT_ZERO) begin
            stateNext = ST_CONV;
            startNow = 1'b1;
          end else begin
            cntNext = cntReg - CNT_ONE;
          end
        end
        ST_CONV: begin
          if (sarBus.done) begin
            stateNext = ST_POST; // hold off the channel
            cntNext = POST_LOAD;
            restartDiv = 1'b1;
          end else if (!goBit || haltAbort) begin
            // firmware clear or halt: result kept
            stateNext = ST_ABORT;
            cntNext = ABORT_LOAD;
            abortNow = 1'b1;
            restartDiv = 1'b1;
          end
        end
        ST_POST, ST_ABORT: begin
          // wait whole bit periods, then acquire again
          if (cntReg == CNT_ZERO) begin
            stateNext = ST_ACQ;
          end else if (tickReg) begin
            cntNext = cntReg - CNT_ONE;
          end
        end
        default: begin
          stateNext = ST_ACQ;
        end
      endcase
    end
    // halt state and power down under oscillator clock
    haltedNext = haltedReg;
    pdNext = pdReg;
    if (haltEnter) begin
      haltedNext = 1'b1;
      pdNext = !rcSel;
    end else if (haltLeave || wakeReg) begin
      haltedNext = 1'b0;
      pdNext = 1'b0;
    end
    // done with its enable set leaves the halt
    wakeNext = sarBus.done && haltedReg && pieReg[IRQ_CONV];
    powerNext = active && ctrlReg[CTRL_ON];
    sampleNext = (stateNext == ST_ACQ) && active;
  end

  // sequencer registers, all cleared by any reset
  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= ST_ACQ;
      cntReg <= CNT_ZERO;
      haltedReg <= 1'b0;
      pdReg <= 1'b0;
      wakeReg <= 1'b0;
      powerReg <= 1'b0;
      sampleReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      cntReg <= cntNext;
      haltedReg <= haltedNext;
      pdReg <= pdNext;
      wakeReg <= wakeNext;
      powerReg <= powerNext;
      sampleReg <= sampleNext;
    end
  end

  // ****************************************
  // registers and flags
  // ****************************************
  always_comb begin
    ctrlNext = ctrlReg;
    intctlNext = intctlReg;
    pieNext = pieReg;
    apselNext = apselReg;
    refNext = refReg;
    pirNext = pirReg;
    resultNext = resultReg;
    if (wrCtrl) begin
      ctrlNext = regWrData; // layout
    end
    if (regWr && (regAddr == ADDR_INTCTL)) begin
      intctlNext = regWrData;
    end
    if (regWr && (regAddr == ADDR_PIEN)) begin
      pieNext = regWrData & IRQ_MASK;
    end
    if (regWr && (regAddr == ADDR_APSEL)) begin
      apselNext = regWrData;
    end
    if (regWr && (regAddr == ADDR_REFCFG)) begin
      refNext = regWrData & REF_MASK;
    end
    if (regWr && (regAddr == ADDR_PIRF)) begin
      pirNext = pirReg & ~(regWrData & IRQ_MASK); // write one to clear
    end
    if (regWr && (regAddr == ADDR_RESULT)) begin
      resultNext = regWrData;
    end
    if (sarBus.done) begin
      ctrlNext[CTRL_GO] = 1'b0; // hardware clear wins
      resultNext = sarBus.trial;
    end
    if (haltAbort) begin
      ctrlNext[CTRL_GO] = 1'b0; // converter_on stays set
    end
    // events set after the clear, so a set wins
    pirNext[IRQ_CONV] = pirNext[IRQ_CONV] | sarBus.done;
    pirNext[IRQ_VDET] = pirNext[IRQ_VDET] | voltageDetectEvent;
    pirNext[IRQ_CMP2] = pirNext[IRQ_CMP2] | cmp2Event;
    pirNext[IRQ_CMP1] = pirNext[IRQ_CMP1] | cmp1Event;
    pirNext[IRQ_TMR1] = pirNext[IRQ_TMR1] | timer1Event;
    irqNext = irqCause;
    // read decode, unmapped reads zero
    rdNext = RST_ZERO;
    if (!regRd) begin
      rdNext = RST_ZERO;
    end else if (regAddr == ADDR_CTRL) begin
      rdNext = ctrlReg;
    end else if (regAddr == ADDR_RESULT) begin
      rdNext = resultReg;
    end else if (regAddr == ADDR_PIRF) begin
      rdNext = pirReg;
    end else if (regAddr == ADDR_PIEN) begin
      rdNext = pieReg;
    end else if (regAddr == ADDR_INTCTL) begin
      rdNext = intctlReg;
    end else if (regAddr == ADDR_APSEL) begin
      rdNext = apselReg;
    end else if (regAddr == ADDR_REFCFG) begin
      rdNext = refReg;
    end
  end

  // register file, reset values
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrlReg <= RST_ZERO;
      intctlReg <= RST_ZERO;
      pirReg <= RST_ZERO;
      pieReg <= RST_ZERO;
      apselReg <= RST_APSEL;
      refReg <= RST_ZERO;
      rdReg <= RST_ZERO;
      irqReg <= 1'b0;
    end else begin
      ctrlReg <= ctrlNext;
      intctlReg <= intctlNext;
      pirReg <= pirNext;
      pieReg <= pieNext;
      apselReg <= apselNext;
      refReg <= refNext;
      rdReg <= rdNext;
      irqReg <= irqNext;
    end
  end

  // no reset value; reset only freezes the result so nothing lands
  always_ff @(posedge clk) begin
    if (!srst) resultReg <= resultNext;
  end

  // outputs
  assign regRdData = rdReg;
  assign irqOut = irqReg;
  assign wakeReq = wakeReg;
  assign sarTrial = sarBus.trial;
  assign sampleConnect = sampleReg;
  assign converterPowered = powerReg;
  assign channelSel = {ctrlReg[CTRL_CH3], ctrlReg[CTRL_CH_HI:CTRL_CH_LO]};
  assign referenceSel = refReg[REF_HI:REF_LO];
  assign analogPinSel = apselReg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic inConv, inDelay, inAbort, inPost;
  assign inConv = (stateReg == ST_CONV);
  assign inDelay = (stateReg == ST_DELAY);
  assign inAbort = (stateReg == ST_ABORT);
  assign inPost = (stateReg == ST_POST);
  sequence s_halt_off;
    inAbort && !goBit && pdReg ##1 !converterPowered;
  endsequence
  sequence s_post_wait;
    inPost && !sampleConnect;
  endsequence

  AST_HALT_ABORT: assert property (
    (inConv && haltEnter && !rcSel && !sarBus.done && ctrlReg[CTRL_ON])
      |=> s_halt_off and (ctrlReg[CTRL_ON] == $past(ctrlReg[CTRL_ON])))
    else $error("halt under oscillator clock did not abort and power down");
  AST_RC_DELAY: assert property (
    ($rose(inConv) && rcSel) |-> ($past(inDelay) && $past(inDelay, 4)))
    else $error("RC conversion started without one instruction cycle wait");
  AST_DONE_CLEAR: assert property (
    sarBus.done |=> (!goBit && pirReg[IRQ_CONV] && resultReg == $past(sarBus.trial)))
    else $error("completion did not clear start flag and load result");
  AST_WAKE: assert property (
    (sarBus.done && haltedReg && pieReg[IRQ_CONV]) |=> wakeReq ##1 !haltedReg)
    else $error("completion in halt did not wake the device");
  AST_HALT_CLOCK: assert property (
    (haltedReg && !rcSel) |-> !tickNext)
    else $error("bit period clock ran during halt without RC source");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> (ctrlReg == RST_ZERO && stateReg == ST_ACQ && !converterPowered))
    else $error("reset did not switch the converter off");
  AST_RESULT_KEEP: assert property (@(posedge clk) disable iff (1'b0)
    (srst && !$past(srst)) |=> resultReg == $past(resultReg))
    else $error("reset changed the result register");
  AST_IRQ: assert property (
    1'b1 |=> irqOut == $past(irqCause))
    else $error("interrupt output does not follow gated flags");
  AST_FW_ABORT: assert property (
    (inConv && !goBit && ctrlReg[CTRL_ON] && !sarBus.done)
      |=> inAbort && resultReg == $past(resultReg) && !sampleConnect)
    else $error("firmware abort did not wait with result kept");
  AST_POST: assert property (
    (sarBus.done && ctrlReg[CTRL_ON]) |=> s_post_wait)
    else $error("channel reconnected right after completion");
  AST_HW_WINS: assert property (
    (sarBus.done && wrCtrl && regWrData[CTRL_GO]) |=> !goBit)
    else $error("firmware write beat hardware clear of start flag");
endmodule : ads_sequencer

// ### logic/ads_pkg.sv
// constants, register map and types of the converter sequencer
// How it works
// - halt conversion only with RC clock selected
// - RC clock: start waits one instruction cycle
// - done clears start flag, loads result
// - done in halt with enable wakes device
// - halt on other clock aborts, powers down
// - reset loads register reset values, converter off, aborts
// - result register untouched by any reset
// - control register field layout, resets zero
// - first code step at reference over 256
// - firmware sets start flag, hardware clears it
// - interrupt needs enable, peripheral and global gates
// - firmware abort keeps result, waits two periods
// - one period disconnected after each conversion
package ads_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 5; // clock period
  localparam int INSTR_NS = 20; // instruction cycle, four oscillator periods
  localparam int INSTR_CYCLES = (INSTR_NS + CLK_NS - 1) / CLK_NS; // least time, round up
  localparam int RC_PERIOD_NS = 4000; // typical private RC bit period
  localparam int RC_PERIOD_CYCLES = RC_PERIOD_NS / CLK_NS;
  localparam int DIV_W = 10; // bit period divider width
  localparam logic [DIV_W-1:0] DIV_F2 = 10'h002; // oscillator / 2
  localparam logic [DIV_W-1:0] DIV_F8 = 10'h008; // oscillator / 8
  localparam logic [DIV_W-1:0] DIV_F32 = 10'h020; // oscillator / 32
  localparam logic [DIV_W-1:0] DIV_RC = DIV_W'(RC_PERIOD_CYCLES); // private RC source
  localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;
  localparam logic [1:0] DELAY_LOAD = 2'(INSTR_CYCLES - 1); // start delay count
  localparam logic [1:0] ABORT_LOAD = 2'h2; // bit periods after abort
  localparam logic [1:0] POST_LOAD = 2'h1; // bit periods after completion
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_INTCTL = 8'h0B; // interrupt_control
  localparam logic [7:0] ADDR_PIRF = 8'h0C; // peripheral_irq_flags
  localparam logic [7:0] ADDR_RESULT = 8'h1E; // conversion_result
  localparam logic [7:0] ADDR_CTRL = 8'h1F; // converter_control_main
  localparam logic [7:0] ADDR_PIEN = 8'h8C; // peripheral_irq_enable
  localparam logic [7:0] ADDR_APSEL = 8'h9D; // analog_pin_select
  localparam logic [7:0] ADDR_REFCFG = 8'h9F; // reference_config
  // control register fields
  localparam int CTRL_CS_HI = 7;
  localparam int CTRL_CS_LO = 6;
  localparam int CTRL_CH_HI = 5;
  localparam int CTRL_CH_LO = 3;
  localparam int CTRL_GO = 2;
  localparam int CTRL_CH3 = 1;
  localparam int CTRL_ON = 0;
  localparam logic [1:0] CLK_RC = 2'h3; // clock select code of the RC source
  // flag and enable layout
  localparam int IRQ_VDET = 7;
  localparam int IRQ_CONV = 6;
  localparam int IRQ_CMP2 = 5;
  localparam int IRQ_CMP1 = 4;
  localparam int IRQ_TMR1 = 0;
  localparam logic [7:0] IRQ_MASK = 8'hF1; // implemented flag bits
  localparam int INTCTL_GLOBAL = 7;
  localparam int INTCTL_PERIPH = 6;
  localparam int REF_HI = 5;
  localparam int REF_LO = 4;
  localparam logic [7:0] REF_MASK = 8'h30;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_APSEL = 8'hFF;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_ACQ = 3'b000, // channel connected, idle
    ST_DELAY = 3'b001, // one instruction cycle wait
    ST_CONV = 3'b011, // successive approximation
    ST_POST = 3'b010, // hold disconnected after done
    ST_ABORT = 3'b110 // wait after abort
  } ads_state_t;

  // clock cycles per bit period for a clock select code
  function automatic logic [DIV_W-1:0] ads_period_cycles(input logic [1:0] sel);
    logic [DIV_W-1:0] n;
    n = DIV_RC;
    case (sel)
      2'h0: n = DIV_F2;
      2'h1: n = DIV_F8;
      2'h2: n = DIV_F32;
      default: n = DIV_RC;
    endcase
    return n;
  endfunction : ads_period_cycles
endpackage : ads_pkg

// ### logic/ads_sar_if.sv
// link between the sequencer and the approximation core
`timescale 1ns/10ps
interface ads_sar_if #(parameter int W = 8);
  logic bitTick; // one bit period elapsed
  logic start; // begin a conversion
  logic abort; // drop the conversion
  logic cmpHigh; // input at or above trial level
  logic done; // conversion finished, one cycle
  logic [W-1:0] trial; // trial code, final code at done
  modport ctrl (output bitTick, start, abort, cmpHigh, input done, trial);
  modport core (input bitTick, start, abort, cmpHigh, output done, trial);
endinterface : ads_sar_if

// ### logic/ads_sar_core.sv
// successive approximation register, one bit per bit period
`timescale 1ns/10ps
module ads_sar_core #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // sequencer side
  ads_sar_if.core sar
);
  import ads_pkg::*;
  logic [W-1:0] trialReg, trialNext; // trial code
  logic [W-1:0] ptrReg, ptrNext; // one-hot bit under test
  logic busyReg, busyNext; // conversion running
  logic doneReg, doneNext; // completion pulse

  // ****************************************
  // approximation step
  // ****************************************
  always_comb begin
    trialNext = trialReg;
    ptrNext = ptrReg;
    busyNext = busyReg;
    doneNext = 1'b0;
    if (sar.abort) begin
      // drop everything, trial left as is
      busyNext = 1'b0;
    end else if (sar.start) begin
      // code k means input at or above k/256 of reference
      ptrNext = {1'b1, {(W-1){1'b0}}};
      trialNext = {1'b1, {(W-1){1'b0}}};
      busyNext = 1'b1;
    end else if (busyReg && sar.bitTick) begin
      // keep bit only if input reaches the trial level
      trialNext = sar.cmpHigh ? trialReg : (trialReg & ~ptrReg);
      if (ptrReg[0]) begin
        busyNext = 1'b0;
        doneNext = 1'b1;
      end else begin
        ptrNext = ptrReg >> 1;
        trialNext = trialNext | (ptrReg >> 1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      trialReg <= '0;
      ptrReg <= '0;
      busyReg <= 1'b0;
      doneReg <= 1'b0;
    end else begin
      trialReg <= trialNext;
      ptrReg <= ptrNext;
      busyReg <= busyNext;
      doneReg <= doneNext;
    end
  end

  assign sar.done = doneReg;
  assign sar.trial = trialReg;
endmodule : ads_sar_core

// ### dv/ads_analog_model.sv
// behavioural analog front end: comparator seen by the sequencer
`timescale 1ns/10ps
module ads_analog_model (
  // clock
  input wire logic clk,
  // sequencer side
  input wire logic [7:0] sarTrial,
  input wire logic converterPowered,
  // analog level set by the bench, in code steps
  input wire logic [7:0] vin,
  output logic cmpHigh
);
  // ****************************************
  // comparator
  // ****************************************
  logic junk = 1'b0; // toggles so an unpowered comparator shows no stable level
  // unpowered output changes every cycle; nothing may be read from it
  always_ff @(posedge clk) begin
    junk <= ~junk;
  end
  // input at or above trial level; code 1 starts one step up
  assign cmpHigh = converterPowered ? (vin >= sarTrial) : junk;
endmodule : ads_analog_model

// ### dv/adc_sleep_reset_sequencer_bench.sv
// self-checking bench of the converter sequencer
`timescale 1ns/10ps
module adc_sleep_reset_sequencer_bench;
  import ads_pkg::*;
  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic clk, srst, regWr, regRd, haltEnter, haltLeave, cmpHigh, wakeReq, irqOut;
  logic sampleConnect, converterPowered;
  logic [7:0] regAddr, regWrData, regRdData, sarTrial, vin, analogPinSel, rd;
  logic [3:0] evt, channelSel; // event pulses: voltage, cmp2, cmp1, timer
  logic [1:0] referenceSel;
  int errorCnt = 0;
  int checked = 0;
  ads_sequencer dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .haltEnter(haltEnter),
    .haltLeave(haltLeave), .wakeReq(wakeReq), .irqOut(irqOut),
    .voltageDetectEvent(evt[3]), .cmp2Event(evt[2]), .cmp1Event(evt[1]),
    .timer1Event(evt[0]), .cmpHigh(cmpHigh), .sarTrial(sarTrial),
    .sampleConnect(sampleConnect), .converterPowered(converterPowered),
    .channelSel(channelSel), .referenceSel(referenceSel), .analogPinSel(analogPinSel));
  ads_analog_model afe (.clk(clk), .sarTrial(sarTrial), .converterPowered(converterPowered),
    .vin(vin), .cmpHigh(cmpHigh));
  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // one-cycle read strobe, data taken in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdData;
    chk($sformatf("reg %h", a), rd, exp);
  endtask : rdc
  // one-cycle pulse on a halt line
  task automatic pulse(input bit enter);
    @(posedge clk);
    if (enter) haltEnter <= 1'b1; else haltLeave <= 1'b1;
    @(posedge clk);
    haltEnter <= 1'b0;
    haltLeave <= 1'b0;
  endtask : pulse
  // bounded wait until the start flag drops, then compare control
  task automatic waitDone(input logic [7:0] exp);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      regAddr <= ADDR_CTRL;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 if (regRdData[CTRL_GO] === 1'b0) break;
    end
    chk("ctrl after done", regRdData, exp);
  endtask : waitDone
  // verdict
  task automatic closeOut();
    $display("mismatches %0d of %0d compares", errorCnt, checked);
    if (errorCnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : closeOut
  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // runs long past the slow RC conversion
  initial begin
    repeat (40000) @(posedge clk);
    errorCnt++;
    closeOut();
  end
  initial begin
    {srst, regWr, regRd, haltEnter, haltLeave} = 5'b10000;
    {regAddr, regWrData, vin, evt} = 28'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // reset values and an unmapped place
    rdc(ADDR_CTRL, 8'h00);
    rdc(ADDR_PIRF, 8'h00);
    rdc(ADDR_PIEN, 8'h00);
    rdc(ADDR_APSEL, 8'hFF);
    rdc(8'h50, 8'h00);
    chk("pins", analogPinSel, 8'hFF);
    wr(ADDR_REFCFG, 8'hFF);
    rdc(ADDR_REFCFG, 8'h30);
    chk("reference", {6'h0, referenceSel}, 8'h03);
    wr(ADDR_CTRL, 8'hFA);
    rdc(ADDR_CTRL, 8'hFA);
    chk("channel", {4'h0, channelSel}, 8'h0F);
    // fast conversion, flag and gated interrupt
    vin <= 8'hA5;
    wr(ADDR_CTRL, 8'h05);
    waitDone(8'h01);
    chk("trial", sarTrial, 8'hA5);
    rdc(ADDR_RESULT, 8'hA5);
    rdc(ADDR_PIRF, 8'h40);
    chk("sample idle", {7'h0, sampleConnect}, 8'h01);
    wr(ADDR_PIEN, 8'h40);
    chk("irq half gated", {7'h0, irqOut}, 8'h00);
    wr(ADDR_INTCTL, 8'hC0);
    @(posedge clk);
    #1 chk("irq gated", {7'h0, irqOut}, 8'h01);
    wr(ADDR_PIRF, 8'h40);
    @(posedge clk);
    #1 chk("irq cleared", {7'h0, irqOut}, 8'h00);
    @(posedge clk);
    evt <= 4'hF;
    @(posedge clk);
    evt <= 4'h0;
    rdc(ADDR_PIRF, 8'hB1);
    wr(ADDR_PIRF, 8'hFF);
    rdc(ADDR_PIRF, 8'h00);
    // slow oscillator divider, another code
    vin <= 8'h17;
    wr(ADDR_CTRL, 8'h85);
    waitDone(8'h81);
    chk("trial slow", sarTrial, 8'h17);
    rdc(ADDR_RESULT, 8'h17);
    // firmware abort on the middle divider keeps the old result
    vin <= 8'h3C;
    wr(ADDR_CTRL, 8'h45);
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 8'h41);
    repeat (90) @(posedge clk);
    rdc(ADDR_RESULT, 8'h17);
    // halt on the fast clock aborts and powers down, on-bit kept
    wr(ADDR_CTRL, 8'h05);
    pulse(1'b1);
    repeat (3) @(posedge clk);
    #1 chk("powered", {7'h0, converterPowered}, 8'h00);
    chk("sample off", {7'h0, sampleConnect}, 8'h00);
    rdc(ADDR_CTRL, 8'h01);
    rdc(ADDR_RESULT, 8'h17);
    pulse(1'b0);
    // reset in mid-conversion: registers clear, result kept
    wr(ADDR_CTRL, 8'h05);
    repeat (8) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk("powered rst", {7'h0, converterPowered}, 8'h00);
    rdc(ADDR_CTRL, 8'h00);
    rdc(ADDR_PIEN, 8'h00);
    rdc(ADDR_REFCFG, 8'h00);
    rdc(ADDR_RESULT, 8'h17);
    // RC clock: conversion runs through halt and wakes the core
    vin <= 8'h5A;
    wr(ADDR_PIEN, 8'h40);
    wr(ADDR_CTRL, 8'hC1);
    wr(ADDR_CTRL, 8'hC5);
    pulse(1'b1);
    repeat (20) @(posedge clk);
    #1 chk("powered rc", {7'h0, converterPowered}, 8'h01);
    for (int i = 0; i < 9000; i++) begin
      @(posedge clk);
      #1 if (wakeReq === 1'b1) break;
    end
    chk("wake", {7'h0, wakeReq}, 8'h01);
    rdc(ADDR_CTRL, 8'hC1);
    rdc(ADDR_RESULT, 8'h5A);
    closeOut();
  end
endmodule : adc_sleep_reset_sequencer_bench
